/* rtl/gpio_bank.sv */
// Bank of general pins with direction, live readback and pin interrupts.
// Assumes an APB master on ref_clk; pins and the 128 Hz tick are async.
//
// Overview of operation
// - Every pin has its own direction bit set by software.
// - Each control register holds 8 bits in its own aligned word.
// - Upper 24 bits are ignored on write and read back as zero.
// - Each pin has a level value bit and a direction bit.
// - Direction one drives the pin, direction zero leaves it input.
// - Writing level value changes only pins that are outputs.
// - Reading level value gives the live pin level in any direction.
// - Each pin has its own interrupt configuration bits.
// - Interrupts trigger on high, low, rising or falling input.
// - Each pin may debounce its input before interrupt detection.
// - Debouncing shifts through two stages on a 128 Hz tick.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

`include "gpio_bank_regs.svh"

module gpio_bank
	import gpio_bank_pkg::*;
#(
	parameter int NUM_PINS = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire apb_req_s apbReq,
	output var apb_rsp_s apbRsp,
	input wire logic tick128,
	input wire logic [NUM_PINS-1:0] pinIn,
	output logic [NUM_PINS-1:0] pinOut,
	output logic [NUM_PINS-1:0] pinOe,
	output logic irq
);

	generate
		if (NUM_PINS < 1 || NUM_PINS > `GPIO_REG_W) begin : gBadPins
			$error("NUM_PINS must lie between 1 and 8");
		end
	endgenerate

	// Reset values at full width, cut to the pin count below
	localparam logic [`GPIO_REG_W-1:0] RST_LEVEL = `GPIO_RST_LEVEL;
	localparam logic [`GPIO_REG_W-1:0] RST_DIR = `GPIO_RST_DIR;
	localparam logic [`GPIO_REG_W-1:0] RST_MASK = `GPIO_RST_MASK;
	localparam logic [`GPIO_REG_W-1:0] RST_TYPE = `GPIO_RST_TYPE;
	localparam logic [`GPIO_REG_W-1:0] RST_POL = `GPIO_RST_POL;
	localparam logic [`GPIO_REG_W-1:0] RST_DEB = `GPIO_RST_DEB;
	localparam logic [`GPIO_REG_W-1:0] RST_STATUS = `GPIO_RST_STATUS;

	// Address decode shared by read setup and write access
	function automatic reg_sel_e regSel(
		input logic [`GPIO_ADDR_W-1:0] addr
	);
		reg_sel_e sel;
		sel = SEL_NONE;
		if (addr == `GPIO_OFS_LEVEL) begin
			sel = SEL_LEVEL;
		end else if (addr == `GPIO_OFS_DIR) begin
			sel = SEL_DIR;
		end else if (addr == `GPIO_OFS_MASK) begin
			sel = SEL_MASK;
		end else if (addr == `GPIO_OFS_TYPE) begin
			sel = SEL_TYPE;
		end else if (addr == `GPIO_OFS_POL) begin
			sel = SEL_POL;
		end else if (addr == `GPIO_OFS_DEB) begin
			sel = SEL_DEB;
		end else if (addr == `GPIO_OFS_STATUS) begin
			sel = SEL_STATUS;
		end
		return sel;
	endfunction : regSel

	function automatic logic irqEvent(
		input irq_mode_e mode,
		input logic lvl,
		input logic prev
	);
		logic hit;
		hit = 1'b0;
		case (mode)
			MODE_LVL_LOW: hit = !lvl;
			MODE_LVL_HIGH: hit = lvl;
			MODE_EDGE_FALL: hit = prev && !lvl;
			MODE_EDGE_RISE: hit = !prev && lvl;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : irqEvent

	// Input synchronisers
	logic [NUM_PINS-1:0] pinMeta_q, pinSync_q;
	logic tickMeta_q, tickSync_q, tickPrev_q;
	logic tickPulse;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
			tickMeta_q <= 1'b0;
			tickSync_q <= 1'b0;
			tickPrev_q <= 1'b0;
		end else begin
			pinMeta_q <= pinIn;
			pinSync_q <= pinMeta_q;
			tickMeta_q <= tick128;
			tickSync_q <= tickMeta_q;
			tickPrev_q <= tickSync_q;
		end
	end

	assign tickPulse = tickSync_q && !tickPrev_q;

	// Register file
	logic [NUM_PINS-1:0] level_q, level_d;
	logic [NUM_PINS-1:0] dir_q, dir_d;
	logic [NUM_PINS-1:0] mask_q, mask_d;
	logic [NUM_PINS-1:0] type_q, type_d;
	logic [NUM_PINS-1:0] pol_q, pol_d;
	logic [NUM_PINS-1:0] deb_q, deb_d;
	logic [NUM_PINS-1:0] status_q, status_d;
	logic [NUM_PINS-1:0] srcPrev_q;
	logic [NUM_PINS-1:0] irqSrc, irqHit;
	logic [`GPIO_DATA_W-1:0] rdata_q, rdata_d;
	logic slvErr_q, slvErr_d;
	logic setup, access;
	reg_sel_e rdSel, wrSel;
	logic [NUM_PINS-1:0] wrBits;

	assign setup = apbReq.psel && !apbReq.penable;
	assign access = apbReq.psel && apbReq.penable;
	assign rdSel = regSel(apbReq.paddr);
	assign wrSel = rdSel;
	// Upper 24 bits are dropped here
	assign wrBits = apbReq.pwdata[NUM_PINS-1:0];

	always_comb begin
		level_d = level_q;
		dir_d = dir_q;
		mask_d = mask_q;
		type_d = type_q;
		pol_d = pol_q;
		deb_d = deb_q;
		status_d = status_q;
		if (access && apbReq.pwrite) begin
			case (wrSel)
				// Input pins keep their latch
				SEL_LEVEL: level_d = (wrBits & dir_q) | (level_q & ~dir_q);
				SEL_DIR: dir_d = wrBits;
				SEL_MASK: mask_d = wrBits;
				SEL_TYPE: type_d = wrBits;
				SEL_POL: pol_d = wrBits;
				SEL_DEB: deb_d = wrBits;
				SEL_STATUS: status_d = status_q & ~wrBits;
				default: status_d = status_q;
			endcase
		end
		// Set wins over clear
		status_d = status_d | irqHit;
	end

	always_comb begin
		rdata_d = rdata_q;
		slvErr_d = slvErr_q;
		if (setup) begin
			rdata_d = '0;
			slvErr_d = 1'b0;
			if (!apbReq.pwrite) begin
				case (rdSel)
					// Live level
					SEL_LEVEL: rdata_d[NUM_PINS-1:0] = pinSync_q;
					SEL_DIR: rdata_d[NUM_PINS-1:0] = dir_q;
					SEL_MASK: rdata_d[NUM_PINS-1:0] = mask_q;
					SEL_TYPE: rdata_d[NUM_PINS-1:0] = type_q;
					SEL_POL: rdata_d[NUM_PINS-1:0] = pol_q;
					SEL_DEB: rdata_d[NUM_PINS-1:0] = deb_q;
					SEL_STATUS: rdata_d[NUM_PINS-1:0] = status_q;
					default: rdata_d = '0;
				endcase
			end
			// Only the word-aligned slots exist
			slvErr_d = (rdSel == SEL_NONE);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			level_q <= RST_LEVEL[NUM_PINS-1:0];
			dir_q <= RST_DIR[NUM_PINS-1:0];
			mask_q <= RST_MASK[NUM_PINS-1:0];
			type_q <= RST_TYPE[NUM_PINS-1:0];
			pol_q <= RST_POL[NUM_PINS-1:0];
			deb_q <= RST_DEB[NUM_PINS-1:0];
			status_q <= RST_STATUS[NUM_PINS-1:0];
			srcPrev_q <= '0;
			rdata_q <= '0;
			slvErr_q <= 1'b0;
		end else begin
			level_q <= level_d;
			dir_q <= dir_d;
			mask_q <= mask_d;
			type_q <= type_d;
			pol_q <= pol_d;
			deb_q <= deb_d;
			status_q <= status_d;
			srcPrev_q <= irqSrc;
			rdata_q <= rdata_d;
			slvErr_q <= slvErr_d;
		end
	end

	// Per-pin input conditioning and event detection
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : gPin
			logic debLevel;
			pin_debounce uDeb (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.levelIn(pinSync_q[i]),
				.tickPulse(tickPulse),
				.levelOut(debLevel)
			);
			// Debounced or direct source
			assign irqSrc[i] = deb_q[i] ? debLevel : pinSync_q[i];
			// Own mode per pin
			assign irqHit[i] = irqEvent(irq_mode_e'({type_q[i], pol_q[i]}),
				irqSrc[i], srcPrev_q[i]);
		end
	endgenerate

	always_comb begin
		apbRsp.pready = 1'b1;
		apbRsp.pslverr = slvErr_q;
		apbRsp.prdata = rdata_q;
	end

	// Direction drives the enable
	assign pinOe = dir_q;
	assign pinOut = level_q;
	assign irq = |(status_q & mask_q);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	AST_DIR_WRITE: assert property (
		access && apbReq.pwrite &&
		wrSel == SEL_DIR |=> pinOe == $past(wrBits))
		else $error("direction write did not reach the output enables");

	AST_INPUT_UNTOUCHED: assert property (
		access && apbReq.pwrite &&
		wrSel == SEL_LEVEL |=> ((pinOut ^ $past(pinOut)) & ~$past(dir_q)) == 0
		&& (pinOut & $past(dir_q)) == ($past(wrBits) & $past(dir_q)))
		else $error("level write disturbed an input pin");

	AST_LATCH_HOLD: assert property (
		!(access && apbReq.pwrite && wrSel == SEL_LEVEL)
		|=> $stable(pinOut))
		else $error("output latch changed without a level write");

	AST_UPPER_ZERO: assert property (
		apbRsp.prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");

	AST_READ_LIVE: assert property (
		setup && !apbReq.pwrite &&
		rdSel == SEL_LEVEL ##1 access |->
		apbRsp.prdata[NUM_PINS-1:0] == $past(pinSync_q))
		else $error("level read did not return the pin level");

	AST_UNMAPPED_ERR: assert property (
		setup && rdSel == SEL_NONE
		|=> apbRsp.pslverr && apbRsp.prdata == 0)
		else $error("unmapped access not flagged");

	AST_W1C: assert property (access && apbReq.pwrite &&
		wrSel == SEL_STATUS && irqHit == 0 |=>
		(status_q & $past(wrBits)) == 0)
		else $error("status bits not cleared by a one");

	AST_RISE_SETS: assert property (
		(irqSrc & ~srcPrev_q & type_q & pol_q) != 0
		|=> (status_q & $past(irqSrc & ~srcPrev_q & type_q & pol_q))
		== $past(irqSrc & ~srcPrev_q & type_q & pol_q))
		else $error("rising edge did not set its status bit");

	AST_FALL_SETS: assert property (
		(~irqSrc & srcPrev_q & type_q & ~pol_q) != 0
		|=> (status_q & $past(~irqSrc & srcPrev_q & type_q & ~pol_q))
		== $past(~irqSrc & srcPrev_q & type_q & ~pol_q))
		else $error("falling edge did not set its status bit");

	AST_HIGH_SETS: assert property (
		(irqSrc & ~type_q & pol_q) != 0 |=>
		(status_q & $past(irqSrc & ~type_q & pol_q))
		== $past(irqSrc & ~type_q & pol_q))
		else $error("high level did not set its status bit");

	// Registers still in reset at the release edge itself
	AST_LOW_SETS: assert property (
		rst_b && (~irqSrc & ~type_q & ~pol_q) != 0 |=>
		(status_q & $past(~irqSrc & ~type_q & ~pol_q))
		== $past(~irqSrc & ~type_q & ~pol_q))
		else $error("low level did not set its status bit");

	// A mask write in the same cycle may legally hide the event
	AST_IRQ_LEVEL: assert property (
		(irqHit & mask_q) != 0 &&
		!(access && apbReq.pwrite && wrSel == SEL_MASK) |=> irq)
		else $error("unmasked event raised no irq");

endmodule : gpio_bank

`default_nettype wire

/* common/gpio_bank_regs.svh */
// Register offsets, reset values and field positions of the pin bank.
// Assumes byte addressing on a 32-bit APB with one word per register.
`ifndef GPIO_BANK_REGS_SVH
`define GPIO_BANK_REGS_SVH

`define GPIO_ADDR_W 12
`define GPIO_DATA_W 32
`define GPIO_REG_W 8

`define GPIO_OFS_LEVEL 12'h000
`define GPIO_OFS_DIR 12'h004
`define GPIO_OFS_MASK 12'h008
`define GPIO_OFS_TYPE 12'h00c
`define GPIO_OFS_POL 12'h010
`define GPIO_OFS_DEB 12'h014
`define GPIO_OFS_STATUS 12'h018

`define GPIO_RST_LEVEL 8'h00
`define GPIO_RST_DIR 8'h00
`define GPIO_RST_MASK 8'h00
`define GPIO_RST_TYPE 8'h00
`define GPIO_RST_POL 8'h00
`define GPIO_RST_DEB 8'h00
`define GPIO_RST_STATUS 8'h00

`define GPIO_TYPE_BIT 1
`define GPIO_POL_BIT 0

`endif

/* common/gpio_bank_pkg.sv */
// Types shared by the pin bank: bus carriers, register select, irq modes.
// Assumes the constants header is on the include path.
`include "gpio_bank_regs.svh"

package gpio_bank_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`GPIO_ADDR_W-1:0] paddr;
		logic [`GPIO_DATA_W-1:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [`GPIO_DATA_W-1:0] prdata;
	} apb_rsp_s;

	typedef enum logic [2:0] {
		SEL_LEVEL,
		SEL_DIR,
		SEL_MASK,
		SEL_TYPE,
		SEL_POL,
		SEL_DEB,
		SEL_STATUS,
		SEL_NONE
	} reg_sel_e;

	// Order gives {type, polarity}
	typedef enum logic [1:0] {
		MODE_LVL_LOW,
		MODE_LVL_HIGH,
		MODE_EDGE_FALL,
		MODE_EDGE_RISE
	} irq_mode_e;

endpackage : gpio_bank_pkg

/* rtl/pin_debounce.sv */
// Two-stage debouncer for one pin, advanced by a slow tick pulse.
// Assumes levelIn and tickPulse are already synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none

module pin_debounce (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic levelIn,
	input wire logic tickPulse,
	output logic levelOut
);

	logic stage1_q, stage1_d;
	logic stage2_q, stage2_d;
	logic level_q, level_d;

	always_comb begin
		stage1_d = stage1_q;
		stage2_d = stage2_q;
		level_d = level_q;
		if (tickPulse) begin
			stage1_d = levelIn;
			stage2_d = stage1_q;
			// Accept only when both stages agree
			if (stage1_q == stage2_q) begin
				level_d = stage2_q;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
			level_q <= level_d;
		end
	end

	assign levelOut = level_q;

	AST_DEB_AGREE: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(level_q != $past(level_q)) |->
		($past(tickPulse) && ($past(stage1_q) == $past(stage2_q))
		&& ($past(stage2_q) == level_q)))
		else $error("debounced level changed without agreeing stages");

endmodule : pin_debounce

`default_nettype wire

/* tb/gpio_bank_bench.sv */
// Self-checking bench for the pin bank: APB master, pin model, verdict.
// Assumes the register header and package are compiled before this file.
`timescale 1ns/10ps
`default_nettype none

`include "gpio_bank_regs.svh"

module gpio_bank_bench;
	import gpio_bank_pkg::*;
	logic ref_clk;
	logic rst_b;
	logic tick128;
	logic irq;
	apb_req_s req;
	apb_rsp_s rsp;
	logic [7:0] pinIn;
	logic [7:0] pinOut;
	logic [7:0] pinOe;
	logic [31:0] rd;
	logic err;
	logic [15:0] lfsr;
	logic [7:0] dirM;
	logic [7:0] latM;
	int bad_count;
	int num_checks;

	gpio_bank #(.NUM_PINS(8)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
		.apbReq(req), .apbRsp(rsp), .tick128(tick128), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .irq(irq));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_step

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		if (n >= 20) begin
			bad_count++;
			$display("BAD %0t no pready", $time);
			give_verdict();
		end
	endtask : apb

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			tick128 <= 1'b1;
			repeat (8) @(posedge ref_clk);
			tick128 <= 1'b0;
			repeat (8) @(posedge ref_clk);
		end
	endtask : tick

	task automatic pin_flip(input int p);
		@(posedge ref_clk);
		pinIn <= pinIn ^ 8'(1 << p);
		repeat (4) @(posedge ref_clk);
	endtask : pin_flip

	initial begin
		req = '0;
		pinIn = 8'h00;
		tick128 = 1'b0;
		rst_b = 1'b0;
		lfsr = 16'h8837;
		dirM = 8'h00;
		latM = 8'h00;
		bad_count = 0;
		num_checks = 0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		chk({pinOut, pinOe, irq}, 32'h0, "reset outputs");
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			// Low pins in low level mode are all pending
			chk(rd, i == 6 ? 32'hff : 32'h0, "reset value");
		end
		apb(1'b0, 12'h01c, 32'h0);
		chk(err, 32'h1, "unmapped error");
		// Random direction, latch and pin levels
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_step(lfsr);
			dirM = lfsr[7:0];
			apb(1'b1, `GPIO_OFS_DIR, {{3{lfsr[15:8]}}, dirM});
			apb(1'b0, `GPIO_OFS_DIR, 32'h0);
			chk(rd, {24'h0, dirM}, "direction");
			chk(pinOe, dirM, "drive enable");
			lfsr = lfsr_step(lfsr);
			latM = (latM & ~dirM) | (lfsr[7:0] & dirM);
			apb(1'b1, `GPIO_OFS_LEVEL, {{3{lfsr[15:8]}}, lfsr[7:0]});
			@(negedge ref_clk);
			chk(pinOut, latM, "output latch");
			@(posedge ref_clk);
			pinIn <= lfsr[15:8];
			repeat (3) @(posedge ref_clk);
			apb(1'b0, `GPIO_OFS_LEVEL, 32'h0);
			chk(rd, {24'h0, pinIn}, "live level");
		end
		// Pins 0..3: low, high, falling, rising
		apb(1'b1, `GPIO_OFS_TYPE, 32'h0c);
		apb(1'b1, `GPIO_OFS_POL, 32'h0a);
		@(posedge ref_clk);
		pinIn <= 8'hf5;
		repeat (4) @(posedge ref_clk);
		apb(1'b1, `GPIO_OFS_STATUS, 32'hff);
		for (int m = 0; m < 4; m++) begin
			pin_flip(m);
			@(negedge ref_clk);
			chk(irq, 32'h0, "masked irq");
			apb(1'b0, `GPIO_OFS_STATUS, 32'h0);
			chk(rd, 32'(1 << m), "status set");
			apb(1'b1, `GPIO_OFS_MASK, 32'(1 << m));
			@(negedge ref_clk);
			chk(irq, 32'h1, "irq raised");
			apb(1'b1, `GPIO_OFS_STATUS, 32'(1 << m));
			apb(1'b0, `GPIO_OFS_STATUS, 32'h0);
			chk(rd, m < 2 ? 32'(1 << m) : 32'h0, "clear");
			pin_flip(m);
			apb(1'b0, `GPIO_OFS_STATUS, 32'h0);
			chk(rd, m < 2 ? 32'(1 << m) : 32'h0, "back");
			apb(1'b1, `GPIO_OFS_STATUS, 32'(1 << m));
			@(negedge ref_clk);
			chk(irq, 32'h0, "irq dropped");
		end
		// Pin 4 rising edge through the debouncer
		pin_flip(4);
		apb(1'b1, `GPIO_OFS_TYPE, 32'h1c);
		apb(1'b1, `GPIO_OFS_POL, 32'h1a);
		apb(1'b1, `GPIO_OFS_DEB, 32'h10);
		apb(1'b1, `GPIO_OFS_STATUS, 32'hff);
		pin_flip(4);
		tick(1);
		pin_flip(4);
		tick(3);
		apb(1'b0, `GPIO_OFS_STATUS, 32'h0);
		chk(rd, 32'h0, "glitch kept out");
		pin_flip(4);
		tick(2);
		apb(1'b0, `GPIO_OFS_STATUS, 32'h0);
		chk(rd, 32'h0, "two ticks");
		tick(1);
		apb(1'b0, `GPIO_OFS_STATUS, 32'h0);
		chk(rd, 32'h10, "third tick");
		give_verdict();
	end
endmodule : gpio_bank_bench

`default_nettype wire
